// ### inc/mbo_consts.svh
// Constants of the memory barrier ordering block: field positions, codes, event and counter indices and the default count width.
`ifndef MBO_CONSTS_SVH
`define MBO_CONSTS_SVH
`define MBO_STYPE_HI 10
`define MBO_STYPE_LO 6
`define MBO_STYPE_FULL 5'h00
`define MBO_STYPE_STORE_ONLY 5'h04
`define MBO_STYPE_LD_ST_ORD 5'h10
`define MBO_STYPE_ACQUIRE 5'h11
`define MBO_STYPE_RELEASE 5'h12
`define MBO_STYPE_LOAD_ONLY 5'h13
`define MBO_STYPE_GINV 5'h14
`define MBO_GI_SUPP_A 2'h2
`define MBO_GI_SUPP_B 2'h3
`define MBO_EV_LD_ISSUE 0
`define MBO_EV_ST_ISSUE 1
`define MBO_EV_LD_DONE 2
`define MBO_EV_ST_DONE 3
`define MBO_EV_LD_ORD 4
`define MBO_EV_ST_ORD 5
`define MBO_EV_GINV_ISSUE 6
`define MBO_EV_GINV_DONE 7
`define MBO_CNT_LD_OPEN 0
`define MBO_CNT_ST_OPEN 1
`define MBO_CNT_LD_UNORD 2
`define MBO_CNT_ST_UNORD 3
`define MBO_CNT_W_DEF 6
`endif

// ### inc/mbo_pkg.sv
// Types shared by the memory barrier ordering block.
package mbo_pkg;
	typedef enum logic [2:0] {
		MBO_IDLE = 3'h1,
		MBO_WAIT = 3'h2,
		MBO_DONE = 3'h4
	} mbo_state_e;

	// What one barrier waits for and what it holds back.
	typedef struct packed {
		logic completion;
		logic ginv;
		logic old_ld;
		logic old_st;
		logic yng_ld;
		logic yng_st;
	} mbo_cls_s;

	// Load/store unit events, one bit each, bit order as the event positions.
	typedef struct packed {
		logic ginv_done;
		logic ginv_issue;
		logic st_ord;
		logic ld_ord;
		logic st_done;
		logic ld_done;
		logic st_issue;
		logic ld_issue;
	} mbo_lsu_evt_s;
endpackage

// ### design/mbo_barrier.sv
// Memory barrier ordering control: decodes the barrier type and stalls younger accesses.
`timescale 1ns/100ps
`include "mbo_consts.svh"
// Overview of operation
// - A barrier written with no type is encoded with type field zero.
// - Type zero is a full completion barrier over older and younger loads and stores.
// - Nonzero types not defined here behave exactly like type zero.
// - Only uncached and cached-coherent accesses are ordered by the barrier.
// - Completion: older selected accesses complete before younger selected ones start.
// - Load complete when register written; store when visible to all processors.
// - Completion: older accesses globally performed before younger ones are performed.
// - Instruction fetches are not ordered by either barrier kind.
// - Ordering: older selected accesses processed by the datapath before younger ones.
// - Older accesses reach the no-reorder stage before younger ones reach it.
// - Ordering: older external requests globally performed before younger ones.
// - With support field 10 or 11, barrier also covers global invalidates.
// - Barrier type is instruction bits 10 down to 6.
// - Codes 4, 10, 11, 12, 13 select store, both, acquire, release, load ordering.
// - Type 14 completes only after earlier global invalidates and icache syncs finish.
module mbo_barrier #(
	parameter int CNT_W = `MBO_CNT_W_DEF
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sync_valid,
	input wire logic [31:0] sync_instr,
	input wire logic [1:0] global_invalidate_support_field,
	input wire mbo_pkg::mbo_lsu_evt_s lsu_evt,
	input wire mbo_pkg::mbo_lsu_evt_s lsu_evt_sync,
	output logic sync_ready,
	output logic sync_done,
	output logic stall_ld,
	output logic stall_st
);
	// One bit cannot hold an access against its own completion; wider counts
	// only cost area, as the event source keeps far fewer accesses in flight.
	if (CNT_W < 2 || CNT_W > 16) begin : g_bad_cnt_w
		$error("mbo_barrier: CNT_W must lie between 2 and 16");
	end

	typedef struct packed {
		mbo_pkg::mbo_state_e state;
		mbo_pkg::mbo_cls_s cls;
		logic [3:0][CNT_W-1:0] cnt;
		logic [CNT_W-1:0] gcnt;
		logic ready;
		logic done;
		logic stall_ld;
		logic stall_st;
	} mbo_st_s;

	localparam mbo_st_s ST_RESET = '{
		state: mbo_pkg::MBO_IDLE,
		cls: '0,
		cnt: '0,
		gcnt: '0,
		ready: 1'b1,
		done: 1'b0,
		stall_ld: 1'b0,
		stall_st: 1'b0
	};

	mbo_st_s s_q;
	mbo_st_s s_d;
	logic [7:0] ev_all;
	logic [7:0] ev_sel;
	logic [3:0][CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] gcnt_nxt;
	logic [4:0] stype;
	logic gi_on;
	logic drained;
	mbo_pkg::mbo_cls_s dec_cls;

	assign ev_all = lsu_evt;
	// Attribute qualification keeps other memory types out of the four access counts.
	assign ev_sel = ev_all & lsu_evt_sync;

	// Counters 0/1 track loads/stores not yet complete, 2/3 those not yet past the
	// ordering point; loads bump the even ones, stores the odd ones.
	for (genvar k = 0; k < 4; k++) begin : g_cnt
		always_comb begin
			cnt_nxt[k] = s_q.cnt[k] + CNT_W'(ev_sel[k % 2]) - CNT_W'(ev_sel[k + 2]);
		end
	end

	// Invalidates and icache syncs are counted whatever the memory type.
	assign gcnt_nxt = s_q.gcnt + CNT_W'(ev_all[`MBO_EV_GINV_ISSUE])
		- CNT_W'(ev_all[`MBO_EV_GINV_DONE]);

	assign stype = sync_instr[`MBO_STYPE_HI:`MBO_STYPE_LO];
	assign gi_on = (global_invalidate_support_field == `MBO_GI_SUPP_A)
		|| (global_invalidate_support_field == `MBO_GI_SUPP_B);

	function automatic mbo_pkg::mbo_cls_s mbo_decode(input logic [4:0] t, input logic gi);
		mbo_pkg::mbo_cls_s c;
		// Default is the full completion barrier; undefined codes land here.
		// Lighter types other than load/store ordering only clear what they leave out, so a missed field errs
		// toward more ordering, never less.
		c = '{completion: 1'b1, ginv: 1'b0, old_ld: 1'b1, old_st: 1'b1,
			yng_ld: 1'b1, yng_st: 1'b1};
		case (t)
			`MBO_STYPE_FULL: begin
				c.completion = 1'b1;
			end
			`MBO_STYPE_STORE_ONLY: begin
				c.completion = 1'b0;
				c.old_ld = 1'b0;
				c.yng_ld = 1'b0;
			end
			`MBO_STYPE_LD_ST_ORD: begin
				c = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
			end
			`MBO_STYPE_ACQUIRE: begin
				c.completion = 1'b0;
				c.old_st = 1'b0;
			end
			`MBO_STYPE_RELEASE: begin
				c.completion = 1'b0;
				c.yng_ld = 1'b0;
			end
			`MBO_STYPE_LOAD_ONLY: begin
				c.completion = 1'b0;
				c.old_st = 1'b0;
				c.yng_st = 1'b0;
			end
			`MBO_STYPE_GINV: begin
				// Without support the code is reserved and runs as type zero.
				c.ginv = gi;
			end
			default: begin
				c.completion = 1'b1;
			end
		endcase
		return c;
	endfunction

	assign dec_cls = mbo_decode(stype, gi_on);

	// Completion waits on the open counts, ordering only on the unordered ones;
	// a completed access has passed the ordering point, so completion covers both.
	always_comb begin
		drained = 1'b1;
		if (s_q.cls.old_ld) begin
			drained = drained && (s_q.cls.completion ? s_q.cnt[`MBO_CNT_LD_OPEN] == '0
				: s_q.cnt[`MBO_CNT_LD_UNORD] == '0);
		end
		if (s_q.cls.old_st) begin
			drained = drained && (s_q.cls.completion ? s_q.cnt[`MBO_CNT_ST_OPEN] == '0
				: s_q.cnt[`MBO_CNT_ST_UNORD] == '0);
		end
		if (s_q.cls.ginv) begin
			drained = drained && (s_q.gcnt == '0);
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.cnt = cnt_nxt;
		s_d.gcnt = gcnt_nxt;
		s_d.done = 1'b0;
		case (s_q.state)
			mbo_pkg::MBO_IDLE: begin
				if (sync_valid) begin
					s_d.cls = dec_cls;
					s_d.state = mbo_pkg::MBO_WAIT;
					s_d.ready = 1'b0;
					// Older-side kinds are held too, so younger loads and stores can never keep
					// an access count the barrier waits on from draining; invalidates are not held.
					// The stall is registered, so the pipeline must itself hold back
					// younger accesses in the accept cycle.
					s_d.stall_ld = dec_cls.yng_ld || dec_cls.old_ld;
					s_d.stall_st = dec_cls.yng_st || dec_cls.old_st;
				end
			end
			mbo_pkg::MBO_WAIT: begin
				if (drained) begin
					// Once past the ordering point the in-order external request
					// path keeps global performance in program order.
					s_d.state = mbo_pkg::MBO_DONE;
					s_d.stall_ld = 1'b0;
					s_d.stall_st = 1'b0;
					s_d.done = 1'b1;
				end
			end
			mbo_pkg::MBO_DONE: begin
				s_d.state = mbo_pkg::MBO_IDLE;
				s_d.ready = 1'b1;
			end
			default: begin
				s_d = ST_RESET;
			end
		endcase
	end

	// Fetch is never stalled from here; instruction fetch stays unordered.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_q <= ST_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_ready = s_q.ready;
	assign sync_done = s_q.done;
	assign stall_ld = s_q.stall_ld;
	assign stall_st = s_q.stall_st;

	logic acc;
	assign acc = sync_valid && s_q.state == mbo_pkg::MBO_IDLE;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_zero_full_stall: assert property (
		acc && stype == `MBO_STYPE_FULL |=> stall_ld && stall_st && s_q.cls.completion)
		else $error("type zero did not start a full completion barrier");
	a_undef_as_zero: assert property (
		acc && stype inside {5'h01, 5'h02, 5'h03, 5'h05, 5'h0F, 5'h15, 5'h1F}
		|=> s_q.cls == 6'h2F)
		else $error("undefined type did not act as type zero");
	a_cmp_drain_ld: assert property (
		$rose(sync_done) && $past(s_q.cls.completion && s_q.cls.old_ld)
		|-> $past(s_q.cnt[`MBO_CNT_LD_OPEN]) == '0)
		else $error("completion barrier released with open loads");
	a_cmp_drain_st: assert property (
		$rose(sync_done) && $past(s_q.cls.completion && s_q.cls.old_st)
		|-> $past(s_q.cnt[`MBO_CNT_ST_OPEN]) == '0)
		else $error("completion barrier released with unperformed stores");
	a_ord_drain: assert property (
		$rose(sync_done) && $past(!s_q.cls.completion && s_q.cls.old_ld)
		|-> $past(s_q.cnt[`MBO_CNT_LD_UNORD]) == '0)
		else $error("ordering barrier released before loads were ordered");
	a_ginv_wait: assert property (
		$rose(sync_done) && $past(s_q.cls.ginv) |-> $past(s_q.gcnt) == '0)
		else $error("invalidate barrier released with invalidates pending");
	a_ginv_reserved: assert property (
		acc && stype == `MBO_STYPE_GINV && !gi_on |=> !s_q.cls.ginv && s_q.cls.completion)
		else $error("unsupported type 14 was not treated as type zero");
	a_ginv_enabled: assert property (
		acc && stype == `MBO_STYPE_GINV && gi_on |=> s_q.cls.ginv)
		else $error("supported type 14 ignored invalidates");
	a_store_only_sel: assert property (
		acc && stype == `MBO_STYPE_STORE_ONLY |=> stall_st && !stall_ld)
		else $error("store ordering barrier stalled the wrong kinds");
	a_stall_until_drain: assert property (
		s_q.state == mbo_pkg::MBO_WAIT && !drained |=> stall_ld == $past(stall_ld)
		&& stall_st == $past(stall_st) && !sync_done)
		else $error("stall dropped before older accesses drained");
	a_release_bound: assert property (
		s_q.state == mbo_pkg::MBO_WAIT && drained |=> sync_done ##1 sync_ready)
		else $error("drained barrier did not release within two cycles");

	// Class and stalls of the lighter types other than store ordering, against the code table; then type 14, drain, done-pulse and busy checks.
	a_acquire_sel: assert property (
		acc && stype == `MBO_STYPE_ACQUIRE |=> s_q.cls == 6'h0B && stall_ld && stall_st)
		else $error("acquire barrier selected the wrong kinds");
	a_release_sel: assert property (
		acc && stype == `MBO_STYPE_RELEASE |=> s_q.cls == 6'h0D && stall_ld && stall_st)
		else $error("release barrier selected the wrong kinds");
	a_load_only_sel: assert property (
		acc && stype == `MBO_STYPE_LOAD_ONLY |=> s_q.cls == 6'h0A && stall_ld && !stall_st)
		else $error("load ordering barrier selected the wrong kinds");
	a_ld_st_sel: assert property (
		acc && stype == `MBO_STYPE_LD_ST_ORD |=> s_q.cls == 6'h0F && stall_ld && stall_st)
		else $error("load and store ordering barrier selected the wrong kinds");
	a_ginv_complete: assert property (
		acc && stype == `MBO_STYPE_GINV && gi_on
		|=> s_q.cls.completion && stall_ld && stall_st)
		else $error("invalidate barrier did not also act as a full completion barrier");
	a_ord_drain_st: assert property (
		$rose(sync_done) && $past(!s_q.cls.completion && s_q.cls.old_st)
		|-> $past(s_q.cnt[`MBO_CNT_ST_UNORD]) == '0)
		else $error("ordering barrier released before stores were ordered");
	a_done_pulse: assert property (
		sync_done |-> (!stall_ld && !stall_st) ##1 (!sync_done && sync_ready))
		else $error("done pulse did not release the stalls and return to idle");
	a_busy_refuse: assert property (
		s_q.state == mbo_pkg::MBO_WAIT && sync_valid |=> s_q.cls == $past(s_q.cls))
		else $error("barrier presented while busy changed the held class");

	// The event source keeps counts below the wrap points; a wrap either way
	// would release a barrier early or hold it for good, so it is flagged here, except an underflow of the invalidate count.
	for (genvar k = 0; k < 4; k++) begin : g_cnt_chk
		a_cnt_no_wrap: assert property (@(posedge clk_sys) disable iff (rst)
			s_q.cnt[k] == '1 |=> s_q.cnt[k] != '0)
			else $error("outstanding access count wrapped past its top");
		a_cnt_no_under: assert property (@(posedge clk_sys) disable iff (rst)
			s_q.cnt[k] == '0 |=> s_q.cnt[k] != '1)
			else $error("access completed or ordered with none outstanding");
	end
	a_gcnt_no_wrap: assert property (
		s_q.gcnt == '1 |=> s_q.gcnt != '0)
		else $error("outstanding invalidate count wrapped past its top");

	c_full_done: cover property (acc && stype == `MBO_STYPE_FULL ##[1:20] sync_done);
	c_acquire: cover property (acc && stype == `MBO_STYPE_ACQUIRE ##[1:20] sync_done);
	c_ginv: cover property (acc && stype == `MBO_STYPE_GINV && gi_on ##[2:20] sync_done);
	c_wait_long: cover property (s_q.state == mbo_pkg::MBO_WAIT [*4] ##1 sync_done);
	c_ord_wait: cover property (acc && stype == `MBO_STYPE_LD_ST_ORD ##[2:20] sync_done);
endmodule

// ### tb/mbo_mem_model.sv
// Behavioural coherent memory side that issues, orders and completes accesses.
`timescale 1ns/100ps
module mbo_mem_model #(
	parameter int LAT = 10
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] go,
	input wire logic coherent,
	input wire logic stall_ld,
	input wire logic stall_st,
	output mbo_pkg::mbo_lsu_evt_s evt,
	output mbo_pkg::mbo_lsu_evt_s evt_sync
);
	logic [2:0] pend;
	int t [3];
	logic [7:0] e;
	// A pending access waits while its kind is stalled, as the issuing pipeline would.
	// Each load or store reaches the ordering point after LAT cycles; every access completes after twice that.
	always @(posedge clk_sys) begin
		e = 8'h00;
		for (int k = 0; k < 3; k++) begin
			if (rst) begin
				pend[k] <= 1'b0;
				t[k] <= 0;
			end else if (t[k] != 0) begin
				t[k] <= (t[k] == 2 * LAT) ? 0 : t[k] + 1;
				if (t[k] == LAT && k < 2) e[k + 4] = 1'b1;
				if (t[k] == 2 * LAT) e[(k == 2) ? 7 : k + 2] = 1'b1;
			end else if (pend[k] && !(k == 0 && stall_ld) && !(k == 1 && stall_st)) begin
				e[(k == 2) ? 6 : k] = 1'b1;
				t[k] <= 1;
				pend[k] <= 1'b0;
			end else if (go[k]) begin
				pend[k] <= 1'b1;
			end
		end
		evt <= e;
		evt_sync <= {2'b00, {6{coherent}}};
	end
endmodule

// ### tb/memory_barrier_ordering_bench.sv
// Self-checking bench for the memory barrier ordering block.
`timescale 1ns/100ps
module memory_barrier_ordering_bench;
	// Type code and expected stalls {load, store}, nothing outstanding, no invalidate support.
	localparam logic [6:0] TBL [10] = '{7'h03, 7'h11, 7'h43, 7'h47, 7'h4B, 7'h4E, 7'h07,
		7'h57, 7'h7F, 7'h53};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sync_valid = 1'b0;
	logic [31:0] sync_instr = 32'h00000000;
	logic [1:0] gi_field = 2'h0;
	logic [2:0] go = 3'h0;
	logic coherent = 1'b1;
	logic sync_ready, sync_done, stall_ld, stall_st, sl, ss, rd;
	mbo_pkg::mbo_lsu_evt_s evt, evt_sync;
	int err_total = 0;
	int n_tests = 0;
	int n_ord = 0;
	int n_done = 0;
	int n, o0, d0;

	always #10 clk_sys = ~clk_sys;

	mbo_barrier uut (.clk_sys(clk_sys), .rst(rst), .sync_valid(sync_valid),
		.sync_instr(sync_instr), .global_invalidate_support_field(gi_field),
		.lsu_evt(evt), .lsu_evt_sync(evt_sync), .sync_ready(sync_ready),
		.sync_done(sync_done), .stall_ld(stall_ld), .stall_st(stall_st));
	mbo_mem_model #(.LAT(10)) mem (.clk_sys(clk_sys), .rst(rst), .go(go), .coherent(coherent),
		.stall_ld(stall_ld), .stall_st(stall_st), .evt(evt), .evt_sync(evt_sync));

	always @(posedge clk_sys) begin
		n_ord += int'(evt.ld_ord);
		n_done += int'(evt.ld_done) + int'(evt.ginv_done);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// Presents one barrier, holds it until taken, returns the cycles to the done pulse.
	// Bits outside the type field carry a mixed nonzero pattern so that only bits 10 to 6 may matter.
	task automatic bar(input logic [4:0] code, output int cyc);
		sync_instr <= {21'h15A5A5, code, 6'h2A};
		sync_valid <= 1'b1;
		@(posedge clk_sys);
		while (sync_ready !== 1'b1) begin
			@(posedge clk_sys);
		end
		sync_valid <= 1'b0;
		#1;
		sl = stall_ld;
		ss = stall_st;
		rd = sync_ready;
		cyc = 1;
		while (sync_done !== 1'b1 && cyc < 400) begin
			@(posedge clk_sys);
			#1;
			cyc++;
		end
		chk({31'h0, sync_done}, 32'h1);
		@(posedge clk_sys);
	endtask

	task automatic issue(input logic [2:0] k);
		go <= k;
		@(posedge clk_sys);
		go <= 3'h0;
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic t_reset();
		chk({29'h0, sync_ready, sync_done, stall_ld | stall_st}, 32'h4);
	endtask

	task automatic t_codes();
		for (int i = 0; i < 10; i++) begin
			bar(TBL[i][6:2], n);
			chk({30'h0, sl, ss}, {30'h0, TBL[i][1:0]});
			chk({31'h0, rd}, 32'h0);
			chk(n, 2);
		end
	endtask

	task automatic t_complete();
		issue(3'h1);
		d0 = n_done;
		bar(5'h00, n);
		chk({30'h0, sl, ss}, 32'h3);
		chk(n_done - d0, 1);
	endtask

	task automatic t_order();
		issue(3'h1);
		o0 = n_ord;
		d0 = n_done;
		bar(5'h10, n);
		chk(n_ord - o0, 1);
		chk(n_done - d0, 0);
		repeat (30) @(posedge clk_sys);
	endtask

	task automatic t_select();
		issue(3'h2);
		bar(5'h13, n);
		chk(n, 2);
		repeat (30) @(posedge clk_sys);
		issue(3'h1);
		bar(5'h04, n);
		chk(n, 2);
		repeat (30) @(posedge clk_sys);
	endtask

	// Cached-incoherent accesses keep their attribute until their done pulse has passed.
	task automatic t_nosync();
		coherent <= 1'b0;
		issue(3'h1);
		bar(5'h00, n);
		chk(n, 2);
		repeat (30) @(posedge clk_sys);
		coherent <= 1'b1;
	endtask

	// Type 14 waits on pending invalidates only where the support field enables it.
	task automatic t_ginv(input logic [1:0] gi, input int exp_done);
		gi_field <= gi;
		issue(3'h4);
		d0 = n_done;
		bar(5'h14, n);
		chk(n_done - d0, exp_done);
		repeat (24) @(posedge clk_sys);
	endtask

	// A reset in mid-barrier drops the held class and every outstanding count.
	task automatic t_midrst();
		issue(3'h1);
		sync_instr <= 32'h00000000;
		sync_valid <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk({30'h0, sync_ready, stall_ld}, 32'h1);
		sync_valid <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		bar(5'h00, n);
		chk(n, 2);
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_codes();
		t_complete();
		t_order();
		t_select();
		t_nosync();
		t_ginv(2'h1, 0);
		t_ginv(2'h2, 1);
		t_ginv(2'h3, 1);
		t_midrst();
		test_done();
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		test_done();
	end
endmodule
